/* File: test/pbk_far_side.sv */
// Push button and comparator flags seen by the controller
module pbk_far_side
	import pbk_pkg::*;
#(
	parameter int TICK_P = 2
) (
	input wire logic aclk,
	output logic key_n,
	output pbk_pkg::pbk_cmp_t cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		key_n = 1'b1;
		cmp = '0;
	end
	// Released key reads high through the pin pull-up
	task automatic press(input int ms);
		@(posedge aclk);
		key_n <= 1'b0;
		repeat (ms * TICK_P) @(posedge aclk);
		key_n <= 1'b1;
	endtask
endmodule

/* File: test/pbk_mode_monitor.sv */
// Port-level checker for the power bank key/mode controller
module pbk_mode_monitor
	import pbk_pkg::*;
#(
	parameter int TICK_CYCLES_P = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic key_n,
	input wire pbk_pkg::pbk_cmp_t cmp_async,
	input wire pbk_pkg::pbk_axi_req_t axi_req,
	input wire pbk_pkg::pbk_axi_rsp_t axi_rsp,
	input wire logic boost_en,
	input wire logic charger_en,
	input wire logic trickle_mode,
	input wire logic torch_en,
	input wire logic lowest_level_indicator,
	input wire logic second_level_indicator,
	input wire logic third_level_indicator,
	input wire logic top_level_indicator
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_clears_all:
	assert property (disable iff (1'b0) !aresetn |=> !boost_en && !torch_en && !charger_en
		&& !lowest_level_indicator && !second_level_indicator && !third_level_indicator
		&& !top_level_indicator) else $error("outputs not cleared by reset");
	a_cutoff_stops_boost:
	assert property ((clk_en && cmp_async.batt_cutoff)[*8] |-> ##2 !boost_en)
		else $error("boost kept running below cutoff");
	a_cutoff_blocks_torch:
	assert property ((clk_en && cmp_async.batt_cutoff && !torch_en)[*8] |=> !torch_en)
		else $error("torch lit below cutoff");
	a_input_stops_boost:
	assert property ((clk_en && cmp_async.vin_detect)[*8] |-> ##2 !boost_en)
		else $error("boost kept running with input present");
	a_charge_excludes_boost:
	assert property (charger_en |-> !boost_en) else $error("charger and boost both on");
	a_uvlo_blocks_charge:
	assert property ((clk_en && !cmp_async.vin_above_uvlo)[*8] |-> ##2 !charger_en)
		else $error("charging below undervoltage level");
	a_ovp_blocks_charge:
	assert property ((clk_en && cmp_async.vin_above_ovp)[*8] |-> ##2 !charger_en)
		else $error("charging above overvoltage level");
	a_trickle_needs_charger:
	assert property (trickle_mode |-> charger_en) else $error("trickle without charger");
	a_bresp_holds_steady:
	assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped early");
	a_read_answer_next:
	assert property (clk_en && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");
endmodule

bind pbk_mode_ctrl pbk_mode_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_mon (
	.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .key_n(key_n), .cmp_async(cmp_async),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .boost_en(boost_en), .charger_en(charger_en),
	.trickle_mode(trickle_mode), .torch_en(torch_en),
	.lowest_level_indicator(lowest_level_indicator),
	.second_level_indicator(second_level_indicator),
	.third_level_indicator(third_level_indicator), .top_level_indicator(top_level_indicator));

/* File: test/power_bank_key_mode_controller_tb.sv */
// Self-checking bench for the power bank key/mode controller
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module power_bank_key_mode_controller_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pbk_pkg::*;
	localparam int TICK = 2;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic clk_en = 1'b1;
	logic key_n;
	pbk_cmp_t cmp;
	pbk_axi_req_t req = '0;
	pbk_axi_rsp_t rsp;
	logic boost_en, charger_en, trickle_mode, torch_en, l0, l1, l2, l3;
	logic [3:0] leds;
	logic [31:0] seed = 32'h875d1b4f;
	logic [31:0] rd;
	logic [1:0] rc;
	int fail_count = 0;
	int n_tests = 0;
	int cnt[4];
	assign leds = {l3, l2, l1, l0};
	always #5 aclk = ~aclk;
	pbk_far_side #(.TICK_P(TICK)) far (.aclk(aclk), .key_n(key_n), .cmp(cmp));
	pbk_mode_ctrl #(.TICK_CYCLES_P(TICK)) dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.key_n(key_n), .cmp_async(cmp), .axi_req(req), .axi_rsp(rsp), .boost_en(boost_en),
		.charger_en(charger_en), .trickle_mode(trickle_mode), .torch_en(torch_en),
		.lowest_level_indicator(l0), .second_level_indicator(l1),
		.third_level_indicator(l2), .top_level_indicator(l3));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Lit cycles of indicator i over a 1000 ms window while charging at step s
	function automatic int chg_on(input int s, input int i);
		return (i < s) ? 1000 * TICK : (i == s) ? int'(CHG_BLINK_ON_MS) * TICK : 0;
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic ms(input int n);
		repeat (n * TICK) @(posedge aclk);
	endtask
	task automatic hang();
		fail_count++;
		wrap_up();
	endtask
	// Handshakes are judged at the falling edge, where the rising-edge values are settled
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] r);
		int k;
		logic ah, wh, bh;
		@(posedge aclk);
		req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1; req.wdata <= d;
		req.wstrb <= s;
		for (k = 0; k < 50; k++) begin
			@(negedge aclk);
			ah = req.awvalid && rsp.awready;
			wh = req.wvalid && rsp.wready;
			bh = req.bready && rsp.bvalid;
			r = rsp.bresp;
			@(posedge aclk);
			if (ah) req.awvalid <= 1'b0;
			if (wh) req.wvalid <= 1'b0;
			if (!req.awvalid && !req.wvalid) req.bready <= 1'b1;
			if (bh) begin req.bready <= 1'b0; break; end
		end
		if (k == 50) hang();
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge aclk);
		req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(negedge aclk);
			if (req.arvalid && rsp.arready) begin @(posedge aclk); req.arvalid <= 1'b0; end
			else if (rsp.rvalid) begin
				d = rsp.rdata; r = rsp.rresp;
				@(posedge aclk); req.rready <= 1'b0; break;
			end
		end
		if (k == 50) hang();
	endtask
	task automatic count_leds(input int n);
		cnt = '{default: 0};
		repeat (n * TICK) begin
			@(negedge aclk);
			for (int i = 0; i < 4; i++) if (leds[i] === 1'b1) cnt[i]++;
		end
	endtask
	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask
	initial begin
		repeat (100000) @(posedge aclk);
		hang();
	end
	initial begin
		repeat (20) @(posedge aclk);
		`CHK("outputs", 8'h0, {boost_en, charger_en, trickle_mode, torch_en, leds})
		aresetn <= 1'b1;
		ms(5);
		axi_rd(STATUS_OFFSET, rd, rc);
		`CHK("status", 32'h9, rd)
		axi_rd(CTRL_OFFSET, rd, rc);
		`CHK("ctrl", {30'h0, CTRL_RESET}, rd)
		seed = lfsr(seed);
		axi_rd({1'b1, seed[2:0]}, rd, rc);
		`CHK("unmapped", {RESP_SLVERR, 32'h0}, {rc, rd})
		axi_wr({1'b1, seed[5:3]}, seed, seed[9:6], rc);
		`CHK("unmapped write", RESP_SLVERR, rc)
		axi_wr(STATUS_OFFSET, 32'hffffffff, 4'hf, rc);
		`CHK("ro write", RESP_OKAY, rc)
		// Lane zero off: the control word must keep its reset value
		axi_wr(CTRL_OFFSET, 32'h2, {seed[12:10], 1'b0}, rc);
		axi_rd(CTRL_OFFSET, rd, rc);
		`CHK("strobe off", {30'h0, CTRL_RESET}, rd)
		axi_wr(CTRL_OFFSET, 32'h3, 4'h1, rc);
		far.press(200); ms(10);
		`CHK("locked key", 1'b0, boost_en)
		axi_wr(CTRL_OFFSET, 32'h1, {seed[15:13], 1'b1}, rc);
		far.press(30); ms(10);
		`CHK("bounce", 1'b0, boost_en)
		tdone("reset and keys");
		far.press(200); ms(10);
		axi_rd(STATUS_OFFSET, rd, rc);
		`CHK("boost on", 2'b11, {boost_en, rd[STATUS_DISPLAY_BIT]})
		// A frozen clock enable must hold the display timer as well
		clk_en <= 1'b0;
		ms(1000);
		clk_en <= 1'b1;
		ms(3100);
		axi_rd(STATUS_OFFSET, rd, rc);
		`CHK("frozen timer", 1'b1, rd[STATUS_DISPLAY_BIT])
		ms(1000);
		axi_rd(STATUS_OFFSET, rd, rc);
		`CHK("display off", 1'b0, rd[STATUS_DISPLAY_BIT])
		count_leds(2000);
		`CHK("idle blink", 250 * TICK, cnt[0])
		`CHK("others dark", 0, cnt[1] + cnt[2] + cnt[3])
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			far.press(100 + int'(seed[8:0])); ms(10);
			axi_rd(STATUS_OFFSET, rd, rc);
			`CHK("redisplay", 2'b11, {boost_en, rd[STATUS_DISPLAY_BIT]})
		end
		far.press(2050); ms(10);
		`CHK("torch on", 2'b11, {torch_en, boost_en})
		far.cmp.batt_cutoff <= 1'b1; ms(10);
		`CHK("cutoff boost", 2'b01, {boost_en, torch_en})
		far.press(200); ms(10);
		`CHK("refuse boost", 1'b0, boost_en)
		far.press(2050); ms(10);
		far.press(2050); ms(10);
		`CHK("refuse torch", 1'b0, torch_en)
		far.cmp.batt_cutoff <= 1'b0;
		tdone("boost and torch");
		far.cmp.batt_low_warn <= 1'b1;
		far.press(200); ms(10);
		axi_rd(STATUS_OFFSET, rd, rc);
		`CHK("warn", 1'b1, rd[STATUS_WARN_BIT])
		count_leds(500);
		`CHK("warn flash", 250 * TICK, cnt[0])
		far.cmp.batt_low_warn <= 1'b0;
		far.cmp.light_load <= 1'b1; ms(2000);
		far.cmp.light_load <= 1'b0; ms(5);
		far.cmp.light_load <= 1'b1; ms(15000);
		`CHK("load restart", 1'b1, boost_en)
		ms(1100);
		`CHK("load off", 1'b0, boost_en)
		far.cmp.light_load <= 1'b0;
		far.press(200); ms(10);
		far.cmp.batt_full <= 1'b1; ms(10);
		`CHK("full off", 1'b0, boost_en)
		far.cmp.batt_full <= 1'b0;
		tdone("warning and shutdown");
		far.press(200); ms(10);
		far.cmp.vin_detect <= 1'b1; far.cmp.vin_above_uvlo <= 1'b1; ms(10);
		`CHK("to charge", 3'b011, {boost_en, charger_en, trickle_mode})
		far.press(200); ms(10);
		`CHK("short masked", 1'b0, boost_en)
		far.cmp.batt_above_trickle <= 1'b1; ms(10);
		`CHK("cc", 2'b10, {charger_en, trickle_mode})
		far.press(2050); ms(10);
		`CHK("chg torch", 1'b1, torch_en)
		for (int k = 0; k < 2; k++) begin
			seed = lfsr(seed);
			far.cmp.level_step <= seed[1:0]; ms(10);
			count_leds(1000);
			for (int i = 0; i < 4; i++) `CHK("level", chg_on(seed[1:0], i), cnt[i])
		end
		far.cmp.charge_at_cutoff <= 1'b1; ms(10);
		`CHK("end", 5'h0f, {charger_en, leds})
		far.cmp.charge_at_cutoff <= 1'b0; far.cmp.batt_at_recharge <= 1'b1; ms(10);
		`CHK("recharge", 1'b1, charger_en)
		far.cmp.batt_at_recharge <= 1'b0; far.cmp.vin_above_ovp <= 1'b1; ms(10);
		`CHK("ovp", 1'b0, charger_en)
		far.cmp.vin_above_ovp <= 1'b0;
		ms(10);
		`CHK("ovp clear", 1'b1, charger_en)
		far.cmp.vin_above_uvlo <= 1'b0;
		ms(10);
		`CHK("uvlo", 1'b0, charger_en)
		far.cmp.vin_detect <= 1'b0; ms(10);
		`CHK("no resume", 1'b0, boost_en)
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		`CHK("reset again", 5'h0, {torch_en, leds})
		aresetn <= 1'b1;
		tdone("charging");
		wrap_up();
	end
endmodule

/* File: verilog/pbk_mode_ctrl.sv */
// Key, boost, charger and indicator controller for a single-cell power bank
module pbk_mode_ctrl
	import pbk_pkg::*;
#(
	parameter int TICK_CYCLES_P = pbk_pkg::TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic key_n,
	input wire pbk_pkg::pbk_cmp_t cmp_async,
	input wire pbk_pkg::pbk_axi_req_t axi_req,
	output pbk_pkg::pbk_axi_rsp_t axi_rsp,
	output logic boost_en,
	output logic charger_en,
	output logic trickle_mode,
	output logic torch_en,
	output logic lowest_level_indicator,
	output logic second_level_indicator,
	output logic third_level_indicator,
	output logic top_level_indicator
);
	import pbk_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYCLES_P + 1);

	if (TICK_CYCLES_P < 2) begin : g_bad_tick
		$error("pbk_mode_ctrl: TICK_CYCLES_P must be at least 2");
	end

	function automatic logic blink_on(input logic [MS_W-1:0] phase,
			input logic [MS_W-1:0] period, input logic [MS_W-1:0] on_ms);
		blink_on = (phase % period) < on_ms;
	endfunction

	function automatic logic [3:0] level_bar(input logic [1:0] step);
		level_bar = 4'((5'h2 << step) - 5'h1);
	endfunction

	// Synchronised pins
	logic key_n_s;
	pbk_cmp_t cmp;

	pbk_pin_sync #(
		.WIDTH($bits(pbk_cmp_t) + 1),
		.RESET_VAL({1'b1, {$bits(pbk_cmp_t){1'b0}}})
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.pin_async({key_n, cmp_async}),
		.pin_stable({key_n_s, cmp})
	);

	// Millisecond timebase
	logic [TICK_W-1:0] tick_cnt_q;
	logic ms_tick;
	logic [MS_W-1:0] phase_q;

	assign ms_tick = (tick_cnt_q == TICK_W'(TICK_CYCLES_P - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_q <= '0;
		end else if (clk_en) begin
			tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + 1'b1;
		end
	end

	// Free blink phase; all patterns divide its wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= '0;
		end else if (clk_en && ms_tick) begin
			phase_q <= (phase_q == PHASE_WRAP_MS - 1'b1) ? '0 : phase_q + 1'b1;
		end
	end

	// Register file state
	logic [1:0] ctrl_q;
	logic charge_permit;
	logic key_lock;

	assign charge_permit = ctrl_q[CTRL_CHARGE_PERMIT_BIT];
	assign key_lock = ctrl_q[CTRL_KEY_LOCK_BIT];

	// Key press timing
	logic pressed;
	logic [MS_W-1:0] press_ms_q;
	logic long_done_q;
	logic short_ev;
	logic long_ev;

	assign pressed = !key_n_s && !key_lock;
	assign long_ev = pressed && ms_tick && !long_done_q
		&& (press_ms_q == LONG_PRESS_MS - 1'b1);
	assign short_ev = !pressed && !long_done_q && (press_ms_q >= DEBOUNCE_MS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			press_ms_q <= '0;
			long_done_q <= 1'b0;
		end else if (clk_en) begin
			if (!pressed) begin
				press_ms_q <= '0;
				long_done_q <= 1'b0;
			end else begin
				// Count saturates so a held key fires one long event only
				if (ms_tick && press_ms_q < LONG_PRESS_MS) begin
					press_ms_q <= press_ms_q + 1'b1;
				end
				if (long_ev) begin
					long_done_q <= 1'b1;
				end
			end
		end
	end

	// Operating mode
	pbk_mode_t mode_q;
	logic [MS_W-1:0] light_ms_q;
	logic light_expired;

	assign light_expired = (light_ms_q >= LIGHT_LOAD_WAIT_MS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= MODE_OFF;
		end else if (clk_en) begin
			case (mode_q)
				MODE_OFF: begin
					if (cmp.vin_detect) begin
						mode_q <= MODE_CHARGE;
					end else if (short_ev && !cmp.batt_cutoff) begin
						mode_q <= MODE_BOOST;
					end
				end
				MODE_BOOST: begin
					if (cmp.vin_detect) begin
						mode_q <= MODE_CHARGE;
					end else if (cmp.batt_full || light_expired || cmp.batt_cutoff) begin
						mode_q <= MODE_OFF;
					end
				end
				MODE_CHARGE: begin
					// Leaving charge lands in off: boost waits for a fresh press
					if (!cmp.vin_detect) begin
						mode_q <= MODE_OFF;
					end
				end
				default: begin
					mode_q <= MODE_OFF;
				end
			endcase
		end
	end

	// Light-load shutdown timer; any gap in the flag restarts it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			light_ms_q <= '0;
		end else if (clk_en) begin
			if (mode_q != MODE_BOOST || !cmp.light_load) begin
				light_ms_q <= '0;
			end else if (ms_tick && !light_expired) begin
				light_ms_q <= light_ms_q + 1'b1;
			end
		end
	end

	// Torch toggle
	logic torch_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			torch_q <= 1'b0;
		end else if (clk_en && long_ev) begin
			if (torch_q) begin
				torch_q <= 1'b0;
			end else if (!cmp.batt_cutoff) begin
				torch_q <= 1'b1;
			end
		end
	end
	// No low-battery term switches the torch off.

	// Level display and low battery warning timers
	logic [MS_W-1:0] disp_ms_q;
	logic [MS_W-1:0] warn_ms_q;
	logic disp_active;
	logic warn_active;
	logic short_usable;

	assign disp_active = (disp_ms_q != '0);
	assign warn_active = (warn_ms_q != '0);
	assign short_usable = short_ev && (mode_q != MODE_CHARGE) && !cmp.vin_detect;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			disp_ms_q <= '0;
		end else if (clk_en) begin
			if (short_usable && !cmp.batt_cutoff && !cmp.batt_low_warn) begin
				disp_ms_q <= DISPLAY_MS;
			end else if (mode_q != MODE_BOOST) begin
				disp_ms_q <= (short_usable) ? disp_ms_q : '0;
			end else if (ms_tick && disp_active) begin
				disp_ms_q <= disp_ms_q - 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warn_ms_q <= '0;
		end else if (clk_en) begin
			if (short_usable && cmp.batt_low_warn) begin
				warn_ms_q <= WARN_MS;
			end else if (mode_q == MODE_CHARGE) begin
				warn_ms_q <= '0;
			end else if (ms_tick && warn_active) begin
				warn_ms_q <= warn_ms_q - 1'b1;
			end
		end
	end

	// Charger sequencing
	pbk_chg_t chg_q;
	logic chg_allowed;

	assign chg_allowed = (mode_q == MODE_CHARGE) && cmp.vin_above_uvlo
		&& !cmp.vin_above_ovp && charge_permit;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chg_q <= CHG_SLEEP;
		end else if (clk_en) begin
			if (!chg_allowed) begin
				chg_q <= CHG_SLEEP;
			end else begin
				case (chg_q)
					CHG_SLEEP: begin
						chg_q <= cmp.batt_above_trickle ? CHG_CC : CHG_TRICKLE;
					end
					CHG_TRICKLE: begin
						if (cmp.batt_above_trickle) begin
							chg_q <= CHG_CC;
						end
					end
					CHG_CC: begin
						if (!cmp.batt_above_trickle) begin
							chg_q <= CHG_TRICKLE;
						end else if (cmp.charge_at_cutoff) begin
							chg_q <= CHG_END;
						end
					end
					CHG_END: begin
						if (cmp.batt_at_recharge) begin
							chg_q <= CHG_CC;
						end
					end
					default: begin
						chg_q <= CHG_SLEEP;
					end
				endcase
			end
		end
	end

	// Indicator pattern
	logic [3:0] led_d;
	logic [3:0] led_q;
	logic [3:0] bar;

	always_comb begin
		bar = level_bar(cmp.level_step);
		led_d = 4'h0;
		if (warn_active) begin
			led_d = {3'h0, blink_on(phase_q, WARN_BLINK_PERIOD_MS, WARN_BLINK_ON_MS)};
		end else begin
			case (mode_q)
				MODE_BOOST: begin
					if (disp_active) begin
						led_d = bar;
					end else begin
						led_d = {3'h0, blink_on(phase_q, IDLE_BLINK_PERIOD_MS,
							IDLE_BLINK_ON_MS)};
					end
				end
				MODE_CHARGE: begin
					if (chg_q == CHG_END) begin
						led_d = 4'hf;
					end else if (chg_q != CHG_SLEEP) begin
						// Lower steps steady, the present step blinks
						led_d = bar >> 1;
						if (blink_on(phase_q, CHG_BLINK_PERIOD_MS, CHG_BLINK_ON_MS)) begin
							led_d = bar;
						end
					end
				end
				default: begin
					led_d = 4'h0;
				end
			endcase
		end
	end

	// Drive outputs from flops
	logic boost_q;
	logic charger_q;
	logic trickle_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boost_q <= 1'b0;
			charger_q <= 1'b0;
			trickle_q <= 1'b0;
			led_q <= 4'h0;
		end else if (clk_en) begin
			boost_q <= (mode_q == MODE_BOOST) && !cmp.vin_detect;
			charger_q <= (chg_q == CHG_TRICKLE) || (chg_q == CHG_CC);
			trickle_q <= (chg_q == CHG_TRICKLE);
			led_q <= led_d;
		end
	end

	assign boost_en = boost_q;
	assign charger_en = charger_q;
	assign trickle_mode = trickle_q;
	assign torch_en = torch_q;
	assign lowest_level_indicator = led_q[0];
	assign second_level_indicator = led_q[1];
	assign third_level_indicator = led_q[2];
	assign top_level_indicator = led_q[3];

	// AXI4-Lite slave: one write and one read in flight
	logic aw_have_q;
	logic w_have_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic [31:0] status_word;

	assign axi_rsp.awready = clk_en && !aw_have_q && !bvalid_q;
	assign axi_rsp.wready = clk_en && !w_have_q && !bvalid_q;
	assign axi_rsp.arready = clk_en && !rvalid_q;
	assign axi_rsp.bvalid = bvalid_q;
	assign axi_rsp.bresp = bresp_q;
	assign axi_rsp.rvalid = rvalid_q;
	assign axi_rsp.rdata = rdata_q;
	assign axi_rsp.rresp = rresp_q;

	assign aw_take = axi_req.awvalid && axi_rsp.awready;
	assign w_take = axi_req.wvalid && axi_rsp.wready;
	assign ar_take = axi_req.arvalid && axi_rsp.arready;
	assign do_write = aw_have_q && w_have_q;

	assign status_word = {18'h0, led_q, warn_active, disp_active, torch_q, chg_q, mode_q};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (clk_en) begin
			if (aw_take) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= axi_req.awaddr;
			end else if (do_write) begin
				aw_have_q <= 1'b0;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				w_data_q <= axi_req.wdata;
				w_strb_q <= axi_req.wstrb;
			end else if (do_write) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Status is read only: writes to it are answered OKAY and dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (clk_en) begin
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q <= RESP_OKAY;
				if (aw_addr_q[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
					if (w_strb_q[0]) begin
						ctrl_q <= w_data_q[1:0];
					end
				end else if (aw_addr_q[ADDR_W-1:2] != STATUS_OFFSET[ADDR_W-1:2]) begin
					bresp_q <= RESP_SLVERR;
				end
			end else if (bvalid_q && axi_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (clk_en) begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rresp_q <= RESP_OKAY;
				if (axi_req.araddr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
					rdata_q <= {30'h0, ctrl_q};
				end else if (axi_req.araddr[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]) begin
					rdata_q <= status_word;
				end else begin
					rdata_q <= '0;
					rresp_q <= RESP_SLVERR;
				end
			end else if (rvalid_q && axi_req.rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end
endmodule

/* File: verilog/pbk_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
module pbk_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_stable
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] stable_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("pbk_pin_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else if (clk_en) begin
			s1_q <= pin_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit moves only once stages two and three agree, so one odd sample never passes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stable_q <= RESET_VAL;
		end else if (clk_en) begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					stable_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign pin_stable = stable_q;
endmodule

/* File: verilog/pbk_pkg.sv */
// Shared constants, states and carrier types for the power bank key/mode controller
package pbk_pkg;

	// Timebase: one millisecond tick derived from the 10 ns clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int MS_W = 15;

	// Key timing in milliseconds
	localparam logic [MS_W-1:0] DEBOUNCE_MS = 15'd60;
	localparam logic [MS_W-1:0] LONG_PRESS_MS = 15'd2000;

	// Display and protection timing in milliseconds
	localparam logic [MS_W-1:0] DISPLAY_MS = 15'd4000;
	localparam logic [MS_W-1:0] WARN_MS = 15'd4000;
	localparam logic [MS_W-1:0] LIGHT_LOAD_WAIT_MS = 15'd16000;

	// Blink patterns: period and on-time in milliseconds
	localparam logic [MS_W-1:0] PHASE_WRAP_MS = 15'd2000;
	localparam logic [MS_W-1:0] IDLE_BLINK_PERIOD_MS = 15'd2000;
	localparam logic [MS_W-1:0] IDLE_BLINK_ON_MS = 15'd250;
	localparam logic [MS_W-1:0] CHG_BLINK_PERIOD_MS = 15'd1000;
	localparam logic [MS_W-1:0] CHG_BLINK_ON_MS = 15'd500;
	localparam logic [MS_W-1:0] WARN_BLINK_PERIOD_MS = 15'd250;
	localparam logic [MS_W-1:0] WARN_BLINK_ON_MS = 15'd125;

	// Register map (byte addresses) and fields
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
	localparam int CTRL_CHARGE_PERMIT_BIT = 0;
	localparam int CTRL_KEY_LOCK_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam int STATUS_MODE_LSB = 0;
	localparam int STATUS_CHG_LSB = 3;
	localparam int STATUS_TORCH_BIT = 7;
	localparam int STATUS_DISPLAY_BIT = 8;
	localparam int STATUS_WARN_BIT = 9;
	localparam int STATUS_LED_LSB = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MODE_OFF = 3'b001,
		MODE_BOOST = 3'b010,
		MODE_CHARGE = 3'b100
	} pbk_mode_t;

	typedef enum logic [3:0] {
		CHG_SLEEP = 4'b0001,
		CHG_TRICKLE = 4'b0010,
		CHG_CC = 4'b0100,
		CHG_END = 4'b1000
	} pbk_chg_t;

	// Comparator flags from the analog side, all active high
	typedef struct packed {
		logic batt_full;
		logic light_load;
		logic batt_low_warn;
		logic batt_cutoff;
		logic vin_detect;
		logic vin_above_uvlo;
		logic vin_above_ovp;
		logic batt_above_trickle;
		logic charge_at_cutoff;
		logic batt_at_recharge;
		logic [1:0] level_step;
	} pbk_cmp_t;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} pbk_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pbk_axi_rsp_t;

endpackage
